// ---- src/secfe_front_end.v ----
// Serial EEPROM SPI slave front end with its write-data FIFO.
// Assumes one system clock far faster than the serial clock; the array,
// write timer and read data sit outside and answer on plain ports.
//
// Function
// - Works in SPI mode 0 and mode 3; idle clock level is irrelevant.
// - Input captured on clock rise, output changed on clock fall.
// - All bytes shift most significant bit first, both directions.
// - First input bit taken on first rise after select falls.
// - First output bit appears on the fall after the instruction.
// - Output floats whenever the device is not selected.
// - Active while selected; standby when deselected and no write runs.
// - Before reset release nothing is decoded; release resets into standby.
// - Brown-out resets and silences the device until a new reset.
// - Hold never pauses or disturbs a running internal write.
// - Pause starts while selected, hold low, clock low.
// - While paused output floats; clock and input ignored, position kept.
// - Pause ends when hold is high during a low clock phase.
// - Deselect during pause drops the command and resets the interface.
// - Data-changing commands need the write enable latch set.
// - Block protect bits make part of the array read-only.
// - Write protect pin and lock bit gate status writes.
// - Each command starts at select fall with the opcode byte.
// - Unknown opcode: ignore input, output floats until deselect.
// - Decode latch set, latch clear, status read/write, array read/write.
// - Decode ident read/lock read, ident write/lock, unique id read.
// - Latch cleared at power-up, clear command and each write commit.
// - Status bit 0 is write busy, bit 1 the write enable latch.
`timescale 1ns/1ps
`include "secfe_defines.vh"

// ****************************************
// Write data FIFO
// ****************************************
module secfe_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rstn,
   // Fill side
   input wire i_in_valid,
   input wire [WIDTH-1:0] i_in_data,
   output wire o_in_ready,
   // Drain side
   output reg o_out_valid,
   output reg [WIDTH-1:0] o_out_data,
   input wire i_out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   // Output stage is a register so the top sees flop outputs
   assign o_in_ready = (count != DEPTH[AW:0]);
   assign push = i_in_valid && o_in_ready;
   assign pop = (count != {(AW+1){1'b0}}) && (!o_out_valid || i_out_ready);

   always @(posedge i_clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         o_out_valid <= 1'b0;
         o_out_data <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
            o_out_data <= mem[rd_ptr];
            o_out_valid <= 1'b1;
         end else if (i_out_ready) begin
            o_out_valid <= 1'b0;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // secfe_fifo

// ****************************************
// Front end top
// ****************************************
module secfe_front_end #(
   parameter ID_SEL_BIT = `SECFE_ID_SEL_BIT
) (
   // Clock and power-on reset
   input wire i_clk_sys,
   input wire i_rstn,
   // Pins
   input wire i_sck,
   input wire i_mosi,
   input wire i_csn,
   input wire i_wpn,
   input wire i_holdn,
   output reg o_miso,
   output reg o_miso_oe,
   // Supply monitor
   input wire i_brownout,
   // Array side
   input wire i_write_busy,
   input wire [7:0] i_rd_data,
   output reg o_rd_req,
   output reg [15:0] o_addr,
   output reg [3:0] o_cmd,
   output reg o_write_go,
   output reg o_status_wr,
   output reg o_standby,
   output reg o_wel,
   output reg o_lock,
   output reg [1:0] o_bp,
   output reg o_overrun,
   // Write data stream
   output wire o_wr_valid,
   output wire [7:0] o_wr_data,
   input wire i_wr_ready
);
   localparam ST_IDLE = 3'h0;
   localparam ST_OPC = 3'h1;
   localparam ST_ADDR = 3'h2;
   localparam ST_DATA = 3'h3;
   localparam ST_WAIT = 3'h4;
   localparam [5:0] PIN_RST = `SECFE_PIN_RST;

   // ****************************************
   // Pin sampling
   // ****************************************
   wire [5:0] pin_raw;
   reg [5:0] pin_s1;
   reg [5:0] pin_s2;
   reg [5:0] pin_s3;
   reg [5:0] pin_f;
   reg [5:0] pin_p;
   assign pin_raw = {i_brownout, i_holdn, i_wpn, i_csn, i_mosi, i_sck};

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_pin
         // Accept a level only once two later stages agree
         always @(posedge i_clk_sys or negedge i_rstn) begin
            if (!i_rstn) begin
               pin_s1[g] <= PIN_RST[g];
               pin_s2[g] <= PIN_RST[g];
               pin_s3[g] <= PIN_RST[g];
               pin_f[g] <= PIN_RST[g];
               pin_p[g] <= PIN_RST[g];
            end else begin
               pin_s1[g] <= pin_raw[g];
               pin_s2[g] <= pin_s1[g];
               pin_s3[g] <= pin_s2[g];
               if (pin_s2[g] == pin_s3[g]) begin
                  pin_f[g] <= pin_s3[g];
               end
               pin_p[g] <= pin_f[g];
            end
         end
      end
   endgenerate

   wire sck_rise = pin_f[0] & ~pin_p[0];
   wire sck_fall = ~pin_f[0] & pin_p[0];
   wire mosi = pin_f[1];
   wire sel = ~pin_f[2];
   wire cs_fall = ~pin_f[2] & pin_p[2];
   wire cs_rise = pin_f[2] & ~pin_p[2];
   wire wpn = pin_f[3];
   wire holdn = pin_f[4];
   wire brown = pin_f[5];

   // ****************************************
   // Decoding helpers
   // ****************************************
   function [3:0] dec_op;
      input [7:0] op;
      begin
         case (op)
            `SECFE_OP_SET_WL: dec_op = `SECFE_CMD_SET_WL;
            `SECFE_OP_CLR_WL: dec_op = `SECFE_CMD_CLR_WL;
            `SECFE_OP_ST_RD: dec_op = `SECFE_CMD_ST_RD;
            `SECFE_OP_ST_WR: dec_op = `SECFE_CMD_ST_WR;
            `SECFE_OP_ARR_RD: dec_op = `SECFE_CMD_ARR_RD;
            `SECFE_OP_ARR_WR: dec_op = `SECFE_CMD_ARR_WR;
            `SECFE_OP_ID_RD: dec_op = `SECFE_CMD_ID_RD;
            `SECFE_OP_ID_WR: dec_op = `SECFE_CMD_ID_WR;
            `SECFE_OP_UID_RD: dec_op = `SECFE_CMD_UID_RD;
            default: dec_op = `SECFE_CMD_NONE;
         endcase
      end
   endfunction

   function is_read;
      input [3:0] c;
      begin
         is_read = (c == `SECFE_CMD_ARR_RD) || (c == `SECFE_CMD_ID_RD) ||
            (c == `SECFE_CMD_LOCK_RD) || (c == `SECFE_CMD_UID_RD);
      end
   endfunction

   function prot;
      input [1:0] bp;
      input [15:0] a;
      begin
         case (bp)
            2'h1: prot = (a >= `SECFE_ADDR_QTR);
            2'h2: prot = (a >= `SECFE_ADDR_HALF);
            2'h3: prot = 1'b1;
            default: prot = 1'b0;
         endcase
      end
   endfunction

   // ****************************************
   // Command engine
   // ****************************************
   reg [2:0] st;
   reg [2:0] bitcnt;
   reg [7:0] rx_sr;
   reg [7:0] tx_sr;
   reg addr_hi_done;
   reg paused;
   reg drv;
   reg dead;
   reg sr_seen;
   reg [7:0] sr_data;
   reg wr_seen;
   reg rd_load;
   reg fifo_push;
   reg [7:0] fifo_byte;
   wire fifo_ready;
   wire [7:0] next_sr = {rx_sr[6:0], mosi};
   wire [7:0] status = {o_lock, 3'h0, o_bp, o_wel, i_write_busy};
   wire [15:0] next_addr = {o_addr[7:0], next_sr};
   wire live = sel & ~paused & ~dead & (st != ST_WAIT) & (st != ST_IDLE);
   wire sr_open = o_wel & ~(o_lock & ~wpn);

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= ST_IDLE;
         bitcnt <= 3'h0;
         rx_sr <= 8'h00;
         tx_sr <= 8'h00;
         addr_hi_done <= 1'b0;
         paused <= 1'b0;
         drv <= 1'b0;
         dead <= 1'b0;
         sr_seen <= 1'b0;
         sr_data <= 8'h00;
         wr_seen <= 1'b0;
         rd_load <= 1'b0;
         fifo_push <= 1'b0;
         fifo_byte <= 8'h00;
         o_miso <= 1'b0;
         o_miso_oe <= 1'b0;
         o_rd_req <= 1'b0;
         o_addr <= 16'h0000;
         o_cmd <= `SECFE_CMD_NONE;
         o_write_go <= 1'b0;
         o_status_wr <= 1'b0;
         o_standby <= 1'b1;
         o_wel <= 1'b0;
         o_lock <= `SECFE_LOCK_RST;
         o_bp <= `SECFE_BP_RST;
         o_overrun <= 1'b0;
      end else begin
         o_rd_req <= 1'b0;
         rd_load <= 1'b0;
         o_write_go <= 1'b0;
         o_status_wr <= 1'b0;
         fifo_push <= 1'b0;
         // Standby waits for any running write to end
         o_standby <= ~sel & ~i_write_busy;
         o_miso_oe <= sel & ~paused & drv & ~dead;
         if (brown) begin
            dead <= 1'b1;
         end
         if (dead || brown) begin
            st <= ST_IDLE;
            o_wel <= 1'b0;
            drv <= 1'b0;
            paused <= 1'b0;
         end else if (cs_fall) begin
            st <= ST_OPC;
            bitcnt <= 3'h0;
            addr_hi_done <= 1'b0;
            drv <= 1'b0;
            sr_seen <= 1'b0;
            wr_seen <= 1'b0;
            paused <= 1'b0;
         end else if (!sel) begin
            // Deselect drops any pause and half command
            paused <= 1'b0;
            drv <= 1'b0;
            st <= ST_IDLE;
            // A deselect in pause commits nothing
            if (cs_rise && st == ST_DATA && bitcnt == 3'h0 &&
               !paused) begin
               case (o_cmd)
                  `SECFE_CMD_SET_WL: o_wel <= 1'b1;
                  `SECFE_CMD_CLR_WL: o_wel <= 1'b0;
                  `SECFE_CMD_ST_WR: begin
                     if (sr_seen && sr_open) begin
                        o_lock <= sr_data[`SECFE_ST_LOCK];
                        o_bp <= {sr_data[`SECFE_ST_BP_HI],
                           sr_data[`SECFE_ST_BP_LO]};
                        o_status_wr <= 1'b1;
                        o_wel <= 1'b0;
                     end
                  end
                  `SECFE_CMD_ARR_WR, `SECFE_CMD_ID_WR,
                  `SECFE_CMD_ID_LOCK: begin
                     if (wr_seen && o_wel) begin
                        o_write_go <= 1'b1;
                        o_wel <= 1'b0;
                     end
                  end
                  default: o_wel <= o_wel;
               endcase
            end
         end else begin
            if (rd_load) begin
               tx_sr <= i_rd_data;
               o_rd_req <= 1'b1;
            end
            // Pause only moves during a low clock phase
            if (!pin_f[0]) begin
               paused <= ~holdn;
            end
            if (live && sck_fall && drv) begin
               o_miso <= tx_sr[7];
               tx_sr <= {tx_sr[6:0], 1'b0};
            end
            if (live && sck_rise) begin
               rx_sr <= next_sr;
               bitcnt <= bitcnt + 3'h1;
               if (bitcnt == 3'h7) begin
                  case (st)
                     ST_OPC: begin
                        o_cmd <= dec_op(next_sr);
                        case (dec_op(next_sr))
                           `SECFE_CMD_NONE: st <= ST_WAIT;
                           `SECFE_CMD_SET_WL, `SECFE_CMD_CLR_WL,
                           `SECFE_CMD_ST_WR: st <= ST_DATA;
                           `SECFE_CMD_ST_RD: begin
                              st <= ST_DATA;
                              tx_sr <= status;
                              drv <= 1'b1;
                           end
                           default: st <= ST_ADDR;
                        endcase
                     end
                     ST_ADDR: begin
                        o_addr <= next_addr;
                        addr_hi_done <= 1'b1;
                        if (addr_hi_done) begin
                           st <= ST_DATA;
                           // Shared opcodes split by one address bit
                           if (next_addr[ID_SEL_BIT]) begin
                              if (o_cmd == `SECFE_CMD_ID_RD) begin
                                 o_cmd <= `SECFE_CMD_LOCK_RD;
                              end else if (o_cmd == `SECFE_CMD_ID_WR) begin
                                 o_cmd <= `SECFE_CMD_ID_LOCK;
                              end
                           end
                           if (is_read(o_cmd)) begin
                              // Fetch once the full address has settled
                              rd_load <= 1'b1;
                              drv <= 1'b1;
                           end
                        end
                     end
                     ST_DATA: begin
                        if (o_cmd == `SECFE_CMD_ST_RD) begin
                           tx_sr <= status;
                        end else if (o_cmd == `SECFE_CMD_ST_WR) begin
                           sr_data <= next_sr;
                           sr_seen <= ~sr_seen;
                        end else if (is_read(o_cmd)) begin
                           rd_load <= 1'b1;
                           o_addr <= o_addr + 16'h0001;
                        end else if (o_cmd == `SECFE_CMD_ARR_WR ||
                           o_cmd == `SECFE_CMD_ID_WR ||
                           o_cmd == `SECFE_CMD_ID_LOCK) begin
                           wr_seen <= 1'b1;
                           o_addr <= o_addr + 16'h0001;
                           // Protected or unlatched bytes never reach FIFO
                           if (o_wel && !(o_cmd == `SECFE_CMD_ARR_WR &&
                              prot(o_bp, o_addr))) begin
                              if (fifo_ready) begin
                                 fifo_push <= 1'b1;
                                 fifo_byte <= next_sr;
                              end else begin
                                 o_overrun <= 1'b1;
                              end
                           end
                        end
                     end
                     default: st <= st;
                  endcase
               end
            end
         end
      end
   end

   // ****************************************
   // Write data buffer
   // ****************************************
   // The serial master cannot be stalled, so a full FIFO flags overrun
   secfe_fifo #(
      .WIDTH(`SECFE_FIFO_WIDTH),
      .DEPTH(`SECFE_FIFO_DEPTH),
      .AW(4)
   ) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_in_valid(fifo_push),
      .i_in_data(fifo_byte),
      .o_in_ready(fifo_ready),
      .o_out_valid(o_wr_valid),
      .o_out_data(o_wr_data),
      .i_out_ready(i_wr_ready)
   );
endmodule // secfe_front_end

// ---- src/secfe_defines.vh ----
// Constants of the serial EEPROM command front end.
// Assumes inclusion by bare name from the design file only.
`ifndef SECFE_DEFINES_VH
`define SECFE_DEFINES_VH

// ****************************************
// Opcodes
// ****************************************
`define SECFE_OP_SET_WL 8'h06
`define SECFE_OP_CLR_WL 8'h04
`define SECFE_OP_ST_RD 8'h05
`define SECFE_OP_ST_WR 8'h01
`define SECFE_OP_ARR_RD 8'h03
`define SECFE_OP_ARR_WR 8'h02
`define SECFE_OP_ID_RD 8'h83
`define SECFE_OP_ID_WR 8'h82
`define SECFE_OP_UID_RD 8'h81

// ****************************************
// Decoded command codes on o_cmd
// ****************************************
`define SECFE_CMD_NONE 4'h0
`define SECFE_CMD_SET_WL 4'h1
`define SECFE_CMD_CLR_WL 4'h2
`define SECFE_CMD_ST_RD 4'h3
`define SECFE_CMD_ST_WR 4'h4
`define SECFE_CMD_ARR_RD 4'h5
`define SECFE_CMD_ARR_WR 4'h6
`define SECFE_CMD_ID_RD 4'h7
`define SECFE_CMD_ID_WR 4'h8
`define SECFE_CMD_LOCK_RD 4'h9
`define SECFE_CMD_ID_LOCK 4'hA
`define SECFE_CMD_UID_RD 4'hB

// ****************************************
// Status byte fields and reset values
// ****************************************
`define SECFE_ST_BUSY 0
`define SECFE_ST_WEL 1
`define SECFE_ST_BP_LO 2
`define SECFE_ST_BP_HI 3
`define SECFE_ST_LOCK 7
`define SECFE_BP_RST 2'h0
`define SECFE_LOCK_RST 1'h0

// ****************************************
// Pin reset levels (sck, mosi, csn, wpn, holdn, brownout), protect bounds, id select bit, FIFO size
// ****************************************
`define SECFE_PIN_RST 6'h1C
`define SECFE_ADDR_QTR 16'hC000
`define SECFE_ADDR_HALF 16'h8000
`define SECFE_ID_SEL_BIT 10
`define SECFE_FIFO_WIDTH 8
`define SECFE_FIFO_DEPTH 16

`endif

// ---- test/secfe_checker.sv ----
// Checker of the front end pin timing and latch rules.
// Assumes a bind to the front end top; sees its ports only.
`timescale 1ns/1ps
module secfe_chk (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rstn,
   // Pins
   input wire i_sck,
   input wire i_csn,
   input wire i_holdn,
   input wire i_brownout,
   input wire i_write_busy,
   // Outputs
   input wire o_miso,
   input wire o_miso_oe,
   input wire o_standby,
   input wire o_wel,
   input wire o_write_go,
   input wire o_status_wr
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);
   // **********
   // Ages
   // **********
   reg [3:0] hi_n, hold_n, bo_n, fall_n;
   reg sck_q;
   // Saturating ages; pins pass a multi-flop sampler first
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         hi_n <= 4'h0;
         hold_n <= 4'h0;
         bo_n <= 4'h0;
         fall_n <= 4'hF;
         sck_q <= 1'b0;
      end else begin
         sck_q <= i_sck;
         hi_n <= !i_csn ? 4'h0 : hi_n + {3'h0, hi_n != 4'hF};
         hold_n <= (i_holdn || i_sck || i_csn) ? 4'h0 :
            hold_n + {3'h0, hold_n != 4'hF};
         bo_n <= bo_n + {3'h0, (i_brownout || bo_n != 4'h0) && bo_n != 4'hF};
         fall_n <= (sck_q && !i_sck) ? 4'h0 : fall_n + {3'h0, fall_n != 4'hF};
      end
   end
   property p_oe; hi_n >= 4'h8 |-> !o_miso_oe; endproperty
   a_oe: assert property (p_oe) else $error("out driven deselected");
   property p_stby; (hi_n >= 4'h8 && bo_n == 4'h0 && $stable(i_write_busy))
      [*3] |=> o_standby == !$past(i_write_busy); endproperty
   a_stby: assert property (p_stby) else $error("standby wrong");
   property p_act; (!i_csn && bo_n == 4'h0) [*8] |=> !o_standby; endproperty
   a_act: assert property (p_act) else $error("standby while on");
   property p_rst; $rose(i_rstn) |-> o_standby && !o_wel && !o_miso_oe;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_bo; bo_n >= 4'hA |-> !o_wel && !o_miso_oe; endproperty
   a_bo: assert property (p_bo) else $error("alive after brownout");
   property p_hold; hold_n >= 4'hC |-> !o_miso_oe; endproperty
   a_hold: assert property (p_hold) else $error("driven in pause");
   property p_go; o_write_go |-> $past(o_wel) && i_csn ##1 !o_write_go;
   endproperty
   a_go: assert property (p_go) else $error("write commit");
   property p_sw; o_status_wr |-> $past(o_wel) ##1 !o_status_wr; endproperty
   a_sw: assert property (p_sw) else $error("status commit");
   property p_wel; o_write_go || o_status_wr |-> ##[0:2] !o_wel; endproperty
   a_wel: assert property (p_wel) else $error("latch kept");
   property p_shift; o_miso_oe && $past(o_miso_oe) && $changed(o_miso)
      |-> fall_n <= 4'h8; endproperty
   a_shift: assert property (p_shift) else $error("out off fall");
endmodule // secfe_chk
bind secfe_front_end secfe_chk secfe_chk_i (
   .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_sck(i_sck), .i_csn(i_csn),
   .i_holdn(i_holdn), .i_brownout(i_brownout), .i_write_busy(i_write_busy),
   .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_standby(o_standby),
   .o_wel(o_wel), .o_write_go(o_write_go), .o_status_wr(o_status_wr));

// ---- test/secfe_master.sv ----
// SPI master model driving select, clock, data in and hold.
// Assumes the bench resolves the shared data out line onto i_miso.
`timescale 1ns/1ps
module secfe_master (
   // Pins to the device
   output logic o_sck,
   output logic o_mosi,
   output logic o_csn,
   output logic o_holdn,
   // Resolved data out line
   input wire logic i_miso
);
   localparam real HALF = 62.5;
   logic cpol;
   // **********
   // Bus tasks
   // **********
   initial begin
      cpol = 1'b0;
      o_sck = 1'b0;
      o_mosi = 1'b0;
      o_csn = 1'b1;
      o_holdn = 1'b1;
   end
   task automatic sel(input logic m3);
      cpol = m3;
      o_sck = m3;
      #HALF;
      o_csn = 1'b0;
      #HALF;
   endtask
   task automatic bits(input logic [7:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      for (int k = 7; k >= 0; k--) begin
         o_sck = 1'b0;
         o_mosi = tx[k];
         #HALF;
         o_sck = 1'b1;
         rx[k] = i_miso;
         #HALF;
      end
   endtask
   task automatic desel();
      #HALF;
      o_sck = cpol;
      #HALF;
      o_csn = 1'b1;
      o_mosi = ~o_mosi;
      // Hold is let go well after select so a deselect in pause is seen
      #(4 * HALF);
      o_holdn = 1'b1;
   endtask
   task automatic hold_on();
      o_sck = 1'b0;
      #HALF;
      o_holdn = 1'b0;
      #(3 * HALF);
      repeat (3) begin
         o_sck = 1'b1;
         o_mosi = ~o_mosi;
         #HALF;
         o_sck = 1'b0;
         #HALF;
      end
   endtask
   task automatic hold_off();
      o_holdn = 1'b1;
      #(2 * HALF);
   endtask
endmodule // secfe_master

// ---- test/tb_secfe_front_end.sv ----
// Self-checking bench of the serial EEPROM front end.
// Assumes the master model on the pins; array data is modelled here.
`timescale 1ns/1ps
module tb_secfe_front_end;
   logic clk = 1'b0, rstn = 1'b0, wpn = 1'b1, bo = 1'b0, busy = 1'b0;
   logic rdy = 1'b0, flt = 1'b0, oe_s = 1'b0, go_s = 1'b0, sw_s = 1'b0;
   logic sck, mosi, csn, holdn, miso, oe, wgo, swr, stby, write_enable_latch, lock, ovr;
   logic wvld, line_q, rdq;
   logic [1:0] bp;
   logic [3:0] cmd;
   logic [7:0] wdat, rx;
   logic [15:0] addr, rq_n = 16'h0000;
   int bad_count = 0, total_checks = 0, cyc = 0;
   initial forever #5 clk = ~clk;
   // Undriven line toggles so a stale bit cannot pass
   always @(posedge clk) flt <= ~flt;
   assign line_q = oe ? miso : flt;
   secfe_master secfe_master_i (.o_sck(sck), .o_mosi(mosi), .o_csn(csn),
      .o_holdn(holdn), .i_miso(line_q));
   secfe_front_end secfe_front_end_i (
      .i_clk_sys(clk), .i_rstn(rstn), .i_sck(sck), .i_mosi(mosi),
      .i_csn(csn), .i_wpn(wpn), .i_holdn(holdn), .o_miso(miso),
      .o_miso_oe(oe), .i_brownout(bo), .i_write_busy(busy),
      .i_rd_data(addr[7:0] ^ 8'h5A), .o_rd_req(rdq), .o_addr(addr),
      .o_cmd(cmd), .o_write_go(wgo), .o_status_wr(swr), .o_standby(stby),
      .o_wel(write_enable_latch), .o_lock(lock), .o_bp(bp), .o_overrun(ovr),
      .o_wr_valid(wvld), .o_wr_data(wdat), .i_wr_ready(rdy));
   // **********
   // Tasks
   // **********
   task automatic finish_test();
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (oe === 1'b1) oe_s <= 1'b1;
      if (wgo === 1'b1) go_s <= 1'b1;
      if (swr === 1'b1) sw_s <= 1'b1;
      if (rdq === 1'b1) rq_n <= rq_n + 16'h0001;
      if (cyc == 80000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic do_reset();
      rstn = 1'b0;
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      // Shortened start-up wait; the block keeps no timer of its own
      repeat (100) @(negedge clk);
   endtask
   task automatic snd(input logic m3, input int n, input logic [31:0] tx);
      secfe_master_i.sel(m3);
      for (int i = 0; i < n; i++)
         secfe_master_i.bits(tx[31-8*i -: 8], rx);
      repeat (2) @(negedge clk);
   endtask
   task automatic dsl();
      secfe_master_i.desel();
      @(negedge clk);
   endtask
   task automatic cmd_f(input logic m3, input int n, input logic [31:0] tx);
      snd(m3, n, tx);
      dsl();
   endtask
   task automatic stw(input logic [7:0] v);
      cmd_f(1'b0, 1, 32'h06000000);
      sw_s = 1'b0;
      cmd_f(1'b0, 2, {8'h01, v, 16'h0000});
   endtask
   task automatic t_decode();
      logic [31:0] op [11] = '{32'h06000000, 32'h04000000, 32'h05000000,
         32'h01000000, 32'h03000000, 32'h02000000, 32'h83000000,
         32'h83040000, 32'h82000000, 32'h82040000, 32'h81000000};
      logic [3:0] ex [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
         4'h9, 4'h8, 4'hA, 4'hB};
      chk({stby, write_enable_latch, lock, bp, cmd, oe}, 10'h200);
      for (int i = 0; i < 11; i++) begin
         snd(1'b0, op[i][31] ? 3 : 1, op[i]);
         chk(cmd, ex[i]);
         dsl();
      end
   endtask
   task automatic t_status();
      @(negedge clk) busy = 1'b1;
      snd(1'b0, 2, 32'h05000000);
      chk(rx, 8'h01);
      dsl();
      cmd_f(1'b1, 1, 32'h06000000);
      snd(1'b1, 2, 32'h05000000);
      chk({write_enable_latch, rx}, 9'h103);
      dsl();
      cmd_f(1'b1, 1, 32'h04000000);
      chk(write_enable_latch, 1'b0);
      @(negedge clk) busy = 1'b0;
   endtask
   task automatic t_stwr();
      stw(8'h04);
      chk({sw_s, write_enable_latch, lock, bp}, 5'h11);
      stw(8'h84);
      chk({lock, bp}, 3'h5);
      @(negedge clk) wpn = 1'b0;
      stw(8'h00);
      chk({sw_s, lock, bp}, 4'h5);
      @(negedge clk) wpn = 1'b1;
      stw(8'h04);
      chk({lock, bp}, 3'h1);
   endtask
   task automatic t_arr();
      go_s = 1'b0;
      cmd_f(1'b0, 4, 32'h02100055);
      chk({go_s, wvld}, 2'h0);
      cmd_f(1'b0, 1, 32'h06000000);
      cmd_f(1'b0, 4, 32'h02C000AA);
      chk(wvld, 1'b0);
      cmd_f(1'b0, 1, 32'h06000000);
      go_s = 1'b0;
      snd(1'b0, 3, 32'h02100000);
      // Drain side stalls while the buffer overfills
      for (int i = 0; i < 18; i++)
         secfe_master_i.bits(8'h20 + i[7:0], rx);
      dsl();
      chk({go_s, write_enable_latch, ovr}, 3'h5);
      for (int i = 0; i < 16; i++) begin
         for (int w = 0; w < 20 && wvld !== 1'b1; w++) @(negedge clk);
         chk(wdat, 16'h0020 + i[15:0]);
         rdy = 1'b1;
         @(negedge clk) rdy = 1'b0;
         @(negedge clk);
      end
      rdy = 1'b1;
      repeat (8) @(negedge clk);
      rdy = 1'b0;
      chk(wvld, 1'b0);
   endtask
   task automatic t_read();
      rq_n = 16'h0000;
      snd(1'b1, 4, 32'h03123400);
      chk({cmd, rx}, 12'h56E);
      secfe_master_i.bits(8'hFF, rx);
      chk(rx, 8'h6F);
      dsl();
      chk(rq_n, 16'h0003);
      chk(addr, 16'h1236);
      oe_s = 1'b0;
      cmd_f(1'b0, 2, 32'hFF060000);
      chk({oe_s, write_enable_latch}, 2'h0);
   endtask
   task automatic t_hold();
      snd(1'b0, 1, 32'h05000000);
      secfe_master_i.hold_on();
      @(negedge clk);
      chk(oe, 1'b0);
      secfe_master_i.hold_off();
      secfe_master_i.bits(8'h00, rx);
      chk(rx, 8'h04);
      dsl();
      snd(1'b0, 1, 32'h06000000);
      secfe_master_i.hold_on();
      dsl();
      chk(write_enable_latch, 1'b0);
      cmd_f(1'b0, 1, 32'h06000000);
      chk(write_enable_latch, 1'b1);
   endtask
   task automatic t_brown();
      @(negedge clk) bo = 1'b1;
      repeat (10) @(negedge clk);
      oe_s = 1'b0;
      cmd_f(1'b0, 1, 32'h06000000);
      cmd_f(1'b0, 2, 32'h05000000);
      chk({write_enable_latch, oe_s}, 2'h0);
      @(negedge clk) bo = 1'b0;
      cmd_f(1'b0, 1, 32'h06000000);
      chk(write_enable_latch, 1'b0);
      do_reset();
      cmd_f(1'b0, 1, 32'h06000000);
      chk(write_enable_latch, 1'b1);
   endtask
   initial begin
      do_reset();
      t_decode();
      t_status();
      t_stwr();
      t_arr();
      t_read();
      t_hold();
      t_brown();
      finish_test();
   end
endmodule // tb_secfe_front_end
